// [core/fmsg_host.sv]
// host controller that drives a parallel flash through its pins, ordered over APB
// assumes the flash answers within its own timing; dq_in and ready_busy_n are synchronous to pclk
//
// Operation
// - wait select-to-data time before trusting reads
// - host flags operation interrupted by reset; software reissues it
// - idle reset finishes quickly; wait release recovery
// - programmer autoselect sets a9 level, address bits
// - protect method uses normal bus cycles
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module fmsg_host (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [fmsg_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   output fmsg_pkg::fmsg_pins_t            flash_pins,
   input  wire logic [fmsg_pkg::DATA_W-1:0] dq_in,
   input  wire logic                       ready_busy_n
);

   fmsg_pkg::fmsg_state_t        st;
   fmsg_pkg::fmsg_state_t        next_st;
   logic [fmsg_pkg::CNT_W-1:0]   cnt;
   logic [fmsg_pkg::CNT_W-1:0]   next_cnt;
   logic [1:0]                   ctrl_op;
   logic                         ctrl_a9id;
   logic                         ctrl_rstid;
   logic                         ctrl_wp;
   logic                         next_a9id;
   logic                         next_rstid;
   logic [fmsg_pkg::ADDR_W-1:0]  addr_reg;
   logic [fmsg_pkg::DATA_W-1:0]  wdata_reg;
   logic [fmsg_pkg::DATA_W-1:0]  rdata;
   logic                         restart_needed;
   logic                         done;
   logic                         access;
   logic                         wr;
   logic                         mapped;
   logic                         idle;
   logic                         start;
   logic                         rd_capture;
   logic                         rst_on_busy;
   logic [1:0]                   wr_op;

   // apb slave, zero wait states
   assign access  = psel & penable;
   assign wr      = access & pwrite;
   assign idle    = (st == fmsg_pkg::FMSG_IDLE);
   assign mapped  = (paddr == fmsg_pkg::OFS_CTRL) | (paddr == fmsg_pkg::OFS_ADDR) |
                    (paddr == fmsg_pkg::OFS_WDATA) | (paddr == fmsg_pkg::OFS_RDATA) |
                    (paddr == fmsg_pkg::OFS_STATUS);
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign wr_op   = pwdata[fmsg_pkg::CTRL_OP_HI:fmsg_pkg::CTRL_OP_LO];
   assign start   = wr & idle & (paddr == fmsg_pkg::OFS_CTRL) & pwdata[fmsg_pkg::CTRL_GO] &
                    (wr_op != 2'h3);

   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         fmsg_pkg::OFS_CTRL: begin
            prdata[fmsg_pkg::CTRL_OP_HI:fmsg_pkg::CTRL_OP_LO] = ctrl_op;
            prdata[fmsg_pkg::CTRL_A9ID]  = ctrl_a9id;
            prdata[fmsg_pkg::CTRL_RSTID] = ctrl_rstid;
            prdata[fmsg_pkg::CTRL_WP]    = ctrl_wp;
         end
         fmsg_pkg::OFS_ADDR:  prdata[fmsg_pkg::ADDR_W-1:0] = addr_reg;
         fmsg_pkg::OFS_WDATA: prdata[fmsg_pkg::DATA_W-1:0] = wdata_reg;
         fmsg_pkg::OFS_RDATA: prdata[fmsg_pkg::DATA_W-1:0] = rdata;
         fmsg_pkg::OFS_STATUS: begin
            prdata[fmsg_pkg::STAT_BUSY]    = ~idle;
            prdata[fmsg_pkg::STAT_RYBY]    = ready_busy_n;
            prdata[fmsg_pkg::STAT_RESTART] = restart_needed;
            prdata[fmsg_pkg::STAT_DONE]    = done;
         end
         default: prdata = 32'h0000_0000;
      endcase
   end

   // qualifier levels as they will stand after this edge; ctrl writes only land while idle
   always_comb begin
      next_a9id  = ctrl_a9id;
      next_rstid = ctrl_rstid;
      if (wr && idle && paddr == fmsg_pkg::OFS_CTRL) begin
         next_a9id  = pwdata[fmsg_pkg::CTRL_A9ID];
         next_rstid = pwdata[fmsg_pkg::CTRL_RSTID];
      end
   end

   // control registers, frozen while an operation runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_op    <= 2'h0;
         ctrl_a9id  <= 1'b0;
         ctrl_rstid <= 1'b0;
         ctrl_wp    <= fmsg_pkg::CTRL_WP_RST;
         addr_reg   <= '0;
         wdata_reg  <= '0;
      end else if (wr && idle) begin
         case (paddr)
            fmsg_pkg::OFS_CTRL: begin
               ctrl_op    <= wr_op;
               ctrl_a9id  <= pwdata[fmsg_pkg::CTRL_A9ID];
               ctrl_rstid <= pwdata[fmsg_pkg::CTRL_RSTID];
               ctrl_wp    <= pwdata[fmsg_pkg::CTRL_WP];
            end
            fmsg_pkg::OFS_ADDR:  addr_reg  <= pwdata[fmsg_pkg::ADDR_W-1:0];
            fmsg_pkg::OFS_WDATA: wdata_reg <= pwdata[fmsg_pkg::DATA_W-1:0];
            default: ;
         endcase
      end
   end

   // sequencer
   always_comb begin
      next_st  = st;
      next_cnt = cnt + 1'b1;
      case (st)
         fmsg_pkg::FMSG_IDLE: begin
            next_cnt = '0;
            if (start) begin
               case (wr_op)
                  fmsg_pkg::FMSG_OP_READ:    next_st = fmsg_pkg::FMSG_RD_ACC;
                  fmsg_pkg::FMSG_OP_WRITE:   next_st = fmsg_pkg::FMSG_WR_SETUP;
                  fmsg_pkg::FMSG_OP_HWRESET: next_st = fmsg_pkg::FMSG_RST_LOW;
                  default:                   next_st = fmsg_pkg::FMSG_IDLE;
               endcase
            end
         end
         fmsg_pkg::FMSG_RD_ACC: begin
            // data is trusted only after the full select-to-data time
            if (cnt == fmsg_pkg::SEL_CYC - 1'b1) begin
               next_st  = fmsg_pkg::FMSG_IDLE;
               next_cnt = '0;
            end
         end
         fmsg_pkg::FMSG_WR_SETUP: begin
            next_st  = fmsg_pkg::FMSG_WR_LOW;
            next_cnt = '0;
         end
         fmsg_pkg::FMSG_WR_LOW: begin
            if (cnt == fmsg_pkg::WE_CYC - 1'b1) begin
               next_st  = fmsg_pkg::FMSG_WR_HOLD;
               next_cnt = '0;
            end
         end
         fmsg_pkg::FMSG_WR_HOLD: begin
            if (cnt == fmsg_pkg::WREC_CYC - 1'b1) begin
               next_st  = fmsg_pkg::FMSG_IDLE;
               next_cnt = '0;
            end
         end
         fmsg_pkg::FMSG_RST_LOW: begin
            if (cnt == fmsg_pkg::RP_CYC - 1'b1) begin
               next_st  = fmsg_pkg::FMSG_RST_WAIT;
               next_cnt = '0;
            end
         end
         fmsg_pkg::FMSG_RST_WAIT: begin
            // busy output stays low until the device's own reset ends
            next_cnt = '0;
            if (ready_busy_n) begin
               next_st = fmsg_pkg::FMSG_RST_REC;
            end
         end
         fmsg_pkg::FMSG_RST_REC: begin
            // recovery before any read after reset release
            if (cnt == fmsg_pkg::RH_CYC - 1'b1) begin
               next_st  = fmsg_pkg::FMSG_IDLE;
               next_cnt = '0;
            end
         end
         default: begin
            next_st  = fmsg_pkg::FMSG_IDLE;
            next_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st  <= fmsg_pkg::FMSG_IDLE;
         cnt <= '0;
      end else begin
         st  <= next_st;
         cnt <= next_cnt;
      end
   end

   // pins follow the state being entered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_pins.addr              <= '0;
         flash_pins.dq_out            <= '0;
         flash_pins.dq_oe_n           <= 1'b1;
         flash_pins.ce_n              <= 1'b1;
         flash_pins.oe_n              <= 1'b1;
         flash_pins.we_n              <= 1'b1;
         flash_pins.reset_n           <= 1'b1;
         flash_pins.reset_id_level    <= 1'b0;
         flash_pins.addr9_id_level    <= 1'b0;
         flash_pins.protect_accel_pin <= fmsg_pkg::CTRL_WP_RST;
      end else begin
         flash_pins.addr    <= addr_reg;
         flash_pins.dq_out  <= wdata_reg;
         // deselected whenever no access runs, so the device rests in standby
         flash_pins.ce_n    <= ~(next_st == fmsg_pkg::FMSG_RD_ACC || next_st == fmsg_pkg::FMSG_WR_SETUP ||
                                 next_st == fmsg_pkg::FMSG_WR_LOW || next_st == fmsg_pkg::FMSG_WR_HOLD);
         flash_pins.oe_n    <= ~(next_st == fmsg_pkg::FMSG_RD_ACC);
         // plain bus cycles also carry the protect method's writes
         flash_pins.we_n    <= ~(next_st == fmsg_pkg::FMSG_WR_LOW);
         flash_pins.dq_oe_n <= ~(next_st == fmsg_pkg::FMSG_WR_SETUP || next_st == fmsg_pkg::FMSG_WR_LOW ||
                                 next_st == fmsg_pkg::FMSG_WR_HOLD);
         flash_pins.reset_n <= ~(next_st == fmsg_pkg::FMSG_RST_LOW);
         // elevated levels as their own qualifiers
         flash_pins.reset_id_level <= next_rstid & (next_st != fmsg_pkg::FMSG_RST_LOW);
         // programmer autoselect: a9 level only across a read, address from the register
         flash_pins.addr9_id_level <= next_a9id & (next_st == fmsg_pkg::FMSG_RD_ACC);
         flash_pins.protect_accel_pin <= ctrl_wp;
      end
   end

   // read data and status flags; set wins over a write-one clear
   assign rd_capture  = (st == fmsg_pkg::FMSG_RD_ACC) && (cnt == fmsg_pkg::SEL_CYC - 1'b1);
   assign rst_on_busy = (st == fmsg_pkg::FMSG_RST_LOW) && (cnt == '0) && !ready_busy_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata          <= '0;
         restart_needed <= 1'b0;
         done           <= 1'b0;
      end else begin
         if (rd_capture) begin
            rdata <= dq_in;
         end
         // reset hit a running operation: software must reissue it
         if (rst_on_busy) begin
            restart_needed <= 1'b1;
         end else if (wr && paddr == fmsg_pkg::OFS_STATUS && pwdata[fmsg_pkg::STAT_RESTART]) begin
            restart_needed <= 1'b0;
         end
         if (!idle && next_st == fmsg_pkg::FMSG_IDLE) begin
            done <= 1'b1;
         end else if (wr && paddr == fmsg_pkg::OFS_STATUS && pwdata[fmsg_pkg::STAT_DONE]) begin
            done <= 1'b0;
         end
      end
   end

   // helper counters for the checks below
   logic [fmsg_pkg::CNT_W-1:0] ce_low_cnt;
   logic [fmsg_pkg::CNT_W-1:0] rst_low_cnt;
   logic [fmsg_pkg::CNT_W-1:0] since_rst_hi;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ce_low_cnt   <= '0;
         rst_low_cnt  <= '0;
         since_rst_hi <= '1;
      end else begin
         ce_low_cnt   <= flash_pins.ce_n ? '0 : ce_low_cnt + 1'b1;
         rst_low_cnt  <= flash_pins.reset_n ? '0 : rst_low_cnt + 1'b1;
         if (!flash_pins.reset_n) begin
            since_rst_hi <= '0;
         end else if (since_rst_hi != '1) begin
            since_rst_hi <= since_rst_hi + 1'b1;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence we_pulse_s;
      (!flash_pins.we_n)[*4] ##1 flash_pins.we_n;
   endsequence

   chk_read_after_select: assert property (rd_capture |-> !flash_pins.oe_n && ce_low_cnt == fmsg_pkg::SEL_CYC - 1'b1)
      else $error("read taken before select-to-data time");
   chk_reset_pulse_len: assert property ($rose(flash_pins.reset_n) |-> $past(rst_low_cnt) == fmsg_pkg::RP_CYC - 1'b1)
      else $error("reset pulse length wrong");
   chk_recover_before_read: assert property (rd_capture |-> since_rst_hi >= fmsg_pkg::RH_CYC)
      else $error("read too soon after reset release");
   chk_restart_flag_set: assert property (rst_on_busy |=> restart_needed)
      else $error("interrupted operation not flagged");
   chk_a9_only_read: assert property (flash_pins.addr9_id_level |-> !flash_pins.oe_n && flash_pins.we_n)
      else $error("a9 level outside a read");
   chk_a9_addr_stable: assert property (flash_pins.addr9_id_level && $past(flash_pins.addr9_id_level)
                                        |-> $stable(flash_pins.addr))
      else $error("address moved under a9 level");
   chk_vid_reset_high: assert property (flash_pins.reset_id_level |-> flash_pins.reset_n)
      else $error("elevated level while reset low");
   chk_write_pulse_form: assert property ($fell(flash_pins.we_n) |-> we_pulse_s)
      else $error("write strobe width wrong");
   chk_write_cycle_pins: assert property (!flash_pins.we_n |-> $stable(flash_pins.reset_id_level) &&
                                          flash_pins.oe_n && !flash_pins.ce_n && !flash_pins.dq_oe_n)
      else $error("write cycle pins inconsistent");

endmodule

// [core/fmsg_pkg.sv]
// package for the flash mode and sector guard host controller
// assumes a 100 MHz pclk; the flash outside answers on its own pins with no clock
package fmsg_pkg;

   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 16;
   localparam int APB_AW = 8;

   // register offsets
   localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [APB_AW-1:0] OFS_ADDR   = 8'h04;
   localparam logic [APB_AW-1:0] OFS_WDATA  = 8'h08;
   localparam logic [APB_AW-1:0] OFS_RDATA  = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h10;

   // field positions
   localparam int CTRL_GO    = 0;
   localparam int CTRL_OP_LO = 1;
   localparam int CTRL_OP_HI = 2;
   localparam int CTRL_A9ID  = 3;
   localparam int CTRL_RSTID = 4;
   localparam int CTRL_WP    = 5;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_RYBY  = 1;
   localparam int STAT_RESTART = 2;
   localparam int STAT_DONE  = 3;

   // reset values
   localparam logic CTRL_WP_RST = 1'b1;

   typedef enum logic [1:0] {
      FMSG_OP_READ    = 2'h0,
      FMSG_OP_WRITE   = 2'h1,
      FMSG_OP_HWRESET = 2'h2
   } fmsg_op_t;

   // timing, ns as given, cycles derived
   localparam int T_CLK_NS  = 10;
   localparam int T_SEL_NS  = 90;
   localparam int T_WE_NS   = 35;
   localparam int T_WREC_NS = 20;
   localparam int T_RP_NS   = 500;
   localparam int T_RH_NS   = 50;

   function automatic int ceil_cyc(input int ns);
      return (ns + T_CLK_NS - 1) / T_CLK_NS;
   endfunction

   localparam logic [CNT_W-1:0] SEL_CYC  = CNT_W'(ceil_cyc(T_SEL_NS));
   localparam logic [CNT_W-1:0] WE_CYC   = CNT_W'(ceil_cyc(T_WE_NS));
   localparam logic [CNT_W-1:0] WREC_CYC = CNT_W'(ceil_cyc(T_WREC_NS));
   localparam logic [CNT_W-1:0] RP_CYC   = CNT_W'(ceil_cyc(T_RP_NS));
   localparam logic [CNT_W-1:0] RH_CYC   = CNT_W'(ceil_cyc(T_RH_NS));

   typedef enum logic [7:0] {
      FMSG_IDLE     = 8'h01,
      FMSG_RD_ACC   = 8'h02,
      FMSG_WR_SETUP = 8'h04,
      FMSG_WR_LOW   = 8'h08,
      FMSG_WR_HOLD  = 8'h10,
      FMSG_RST_LOW  = 8'h20,
      FMSG_RST_WAIT = 8'h40,
      FMSG_RST_REC  = 8'h80
   } fmsg_state_t;

   // pins driven toward the flash
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe_n;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              reset_n;
      logic              reset_id_level;
      logic              addr9_id_level;
      logic              protect_accel_pin;
   } fmsg_pins_t;

endpackage

// [verif/fmsg_flash_model.sv]
// behavioural parallel flash with sector guard, seen through the host's pin struct
// assumes pins change just after rising pclk edges; pclk paces the model's timers and samples the write strobe, address and last data
`timescale 1ns/1ps

module fmsg_flash_model #(
   parameter int          PROG_CYC   = 40,
   parameter int          RSEQ_CYC   = 70,
   parameter int          ACC_CYC    = 8,
   parameter bit          TOP_BOOT   = 1'b0,
   parameter logic [7:0]  ID_CODE    = 8'h5a,   // arbitrary value
   parameter logic [15:0] PROT_KEY   = 16'h0060,
   parameter logic [15:0] UNPROT_KEY = 16'h0040
) (
   input  wire logic                 pclk,
   input  wire fmsg_pkg::fmsg_pins_t pins,
   output logic [15:0]               dq,
   output logic                      ready_busy_n
);
   logic [15:0]  mem [4096];
   logic [511:0] prot    = '0;
   logic [15:0]  last    = 16'h0000;
   logic [20:0]  addr_q  = '0;
   logic [20:0]  pend_a  = '0;
   logic [15:0]  pend_d  = '0;
   logic         we_q    = 1'b1;
   logic         aborted = 1'b0;
   int           busy_cnt = 0;
   int           sel_cnt  = 0;
   logic [8:0]   sec;
   logic         boot;
   logic         locked;

   // folded index: only a small window of the array is modelled
   function automatic logic [11:0] idx(input logic [20:0] a);
      return {a[20], a[14:12], a[7:0]};
   endfunction

   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;   // erased array, read mode at power-up
   end

   assign sec          = pins.addr[20:12];
   assign boot         = TOP_BOOT ? (sec >= 9'h1fe) : (sec < 9'h002);
   assign locked       = !pins.reset_id_level && (prot[sec] || (!pins.protect_accel_pin && boot));
   assign ready_busy_n = (busy_cnt == 0);

   always @* begin
      if (!pins.reset_n || pins.ce_n || pins.oe_n || sel_cnt < ACC_CYC)
         dq = ~last;
      else if (pins.addr9_id_level)
         dq = pins.addr[1] ? {15'h0000, prot[sec]} : {8'h00, ID_CODE};
      else
         dq = mem[idx(pins.addr)];
   end

   always @(posedge pclk) begin
      we_q    <= pins.we_n;
      addr_q  <= pins.addr;
      last    <= dq;
      sel_cnt <= (!pins.ce_n && !pins.oe_n && pins.reset_n && pins.addr == addr_q) ? sel_cnt + 1 : 0;
      if (!pins.reset_n && busy_cnt > 0 && !aborted) begin
         aborted  <= 1'b1;
         busy_cnt <= RSEQ_CYC;
      end else if (busy_cnt > 0) begin   // runs on when deselected
         busy_cnt <= busy_cnt - 1;
         if (busy_cnt == 1 && !aborted)
            mem[idx(pend_a)] <= pend_d;
         if (busy_cnt == 1)
            aborted <= 1'b0;
      end else if (pins.we_n && !we_q && !pins.ce_n && pins.oe_n && pins.reset_n) begin
         if (pins.reset_id_level && pins.dq_out == PROT_KEY)
            prot[sec] <= 1'b1;
         else if (pins.reset_id_level && pins.dq_out == UNPROT_KEY)
            prot[sec] <= 1'b0;
         else if (!locked) begin
            pend_a   <= pins.addr;
            pend_d   <= pins.dq_out;
            busy_cnt <= PROG_CYC;
         end
      end
   end
endmodule

// [verif/fmsg_host_bench.sv]
// self-checking bench: APB master tasks, flash model on the pins
// assumes the package and the flash model are compiled before this file
`timescale 1ns/1ps

module fmsg_host_bench;
   localparam logic [15:0] KEY_P = 16'h0060;
   localparam logic [15:0] KEY_U = 16'h0040;
   typedef struct packed {
      logic [20:0] a;
      logic [15:0] d;
      logic        wp;
      logic        rid;
      logic [15:0] exp;
   } fmsg_row_t;
   localparam fmsg_row_t ROWS [14] = '{
      '{21'h00_5000, 16'h1234, 1'b1, 1'b0, 16'h1234},
      '{21'h00_6000, KEY_P,    1'b1, 1'b1, 16'hffff},
      '{21'h00_6000, 16'h5678, 1'b1, 1'b0, 16'hffff},
      '{21'h00_6000, 16'h5678, 1'b1, 1'b1, 16'h5678},
      '{21'h00_6001, 16'h9abc, 1'b1, 1'b0, 16'hffff},
      '{21'h00_0010, 16'h1111, 1'b0, 1'b0, 16'hffff},
      '{21'h00_1010, 16'h1111, 1'b0, 1'b0, 16'hffff},
      '{21'h00_2010, 16'h2222, 1'b0, 1'b0, 16'h2222},
      '{21'h1f_f010, 16'h3333, 1'b0, 1'b0, 16'h3333},
      '{21'h00_0010, 16'h4444, 1'b1, 1'b0, 16'h4444},
      '{21'h00_6002, KEY_U,    1'b1, 1'b1, 16'hffff},
      '{21'h00_6002, 16'h7777, 1'b1, 1'b0, 16'h7777},
      '{21'h00_1020, KEY_P,    1'b1, 1'b1, 16'hffff},
      '{21'h00_1020, 16'h8888, 1'b1, 1'b0, 16'hffff}};

   logic                              pclk    = 1'b0;
   logic                              presetn = 1'b0;
   logic                              psel    = 1'b0;
   logic                              penable = 1'b0;
   logic                              pwrite  = 1'b0;
   logic [fmsg_pkg::APB_AW-1:0]       paddr   = '0;
   logic [31:0]                       pwdata  = 32'h0000_0000;
   logic [31:0]                       prdata;
   logic                              pready;
   logic                              pslverr;
   fmsg_pkg::fmsg_pins_t              flash_pins;
   logic [fmsg_pkg::DATA_W-1:0]       dq_in;
   logic                              ready_busy_n;
   logic [31:0]                       rd;
   logic                              serr;
   int                                err_total  = 0;
   int                                n_compared = 0;

   always #5 pclk = ~pclk;

   fmsg_host fmsg_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_pins(flash_pins), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
   fmsg_flash_model #(.PROT_KEY(KEY_P), .UNPROT_KEY(KEY_U)) fmsg_flash_model_i (.pclk(pclk),
      .pins(flash_pins), .dq(dq_in), .ready_busy_n(ready_busy_n));

   task automatic finish_test();
      if (err_total == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] ctrl(input logic wp, input logic rid, input logic a9, input logic [1:0] opc);
      return {26'h000_0000, wp, rid, a9, opc, 1'b1};
   endfunction

   // entered just after a rising edge; answer and read data taken at the rising edge that finds pready high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic rdy;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         rdy  = pready;
         rd   = prdata;
         serr = pslverr;
      end while (rdy !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wait_idle(input logic need_ry);
      rd = 32'h0000_0001;
      for (int i = 0; i < 400 && (rd[0] !== 1'b0 || (need_ry && rd[1] !== 1'b1)); i++)
         apb(1'b0, fmsg_pkg::OFS_STATUS, 32'h0000_0000);
      // a poll limit that runs out is a failure of its own
      if (rd[0] !== 1'b0 || (need_ry && rd[1] !== 1'b1)) begin
         err_total++;
         $display("BAD wait_idle expected %b seen %b", {need_ry, 1'b0}, rd[1:0]);
      end
   endtask

   task automatic op(input logic [20:0] a, input logic [15:0] d, input logic [31:0] c);
      apb(1'b1, fmsg_pkg::OFS_ADDR, {11'h000, a});
      apb(1'b1, fmsg_pkg::OFS_WDATA, {16'h0000, d});
      apb(1'b1, fmsg_pkg::OFS_CTRL, c);
      wait_idle(1'b1);
   endtask

   task automatic chk_flash(input string what, input logic [20:0] a, input logic a9, input logic [15:0] exp);
      op(a, 16'h0000, ctrl(1'b1, 1'b0, a9, fmsg_pkg::FMSG_OP_READ));
      apb(1'b0, fmsg_pkg::OFS_RDATA, 32'h0000_0000);
      cmp(what, {16'h0000, exp}, rd);
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      cmp("pins_in_reset", 32'h0000_00f9, {24'h00_0000, flash_pins[7:0]});
      presetn <= 1'b1;
      apb(1'b0, fmsg_pkg::OFS_CTRL, 32'h0000_0000);
      cmp("ctrl_reset", 32'h0000_0020, rd);
      apb(1'b0, fmsg_pkg::OFS_STATUS, 32'h0000_0000);
      cmp("status_reset", 32'h0000_0002, rd);
      apb(1'b0, 8'h14, 32'h0000_0000);
      cmp("unmapped_read", 32'h0000_0001, {rd[30:0], serr});
      foreach (ROWS[i]) begin
         op(ROWS[i].a, ROWS[i].d, ctrl(ROWS[i].wp, ROWS[i].rid, 1'b0, fmsg_pkg::FMSG_OP_WRITE));
         chk_flash("row_rdata", ROWS[i].a, 1'b0, ROWS[i].exp);
      end
      // program cut short by a hardware reset, then reissued
      apb(1'b1, fmsg_pkg::OFS_ADDR, 32'h0000_3000);
      apb(1'b1, fmsg_pkg::OFS_WDATA, 32'h0000_abcd);
      apb(1'b1, fmsg_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, fmsg_pkg::FMSG_OP_WRITE));
      wait_idle(1'b0);
      apb(1'b1, fmsg_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, fmsg_pkg::FMSG_OP_HWRESET));
      cmp("reset_pin_low", 32'h0000_0000, {31'h0000_0000, flash_pins.reset_n});
      wait_idle(1'b1);
      cmp("restart_flag", 32'h0000_0004, rd & 32'h0000_0004);
      chk_flash("aborted_word", 21'h00_3000, 1'b0, 16'hffff);
      op(21'h00_3000, 16'habcd, ctrl(1'b1, 1'b0, 1'b0, fmsg_pkg::FMSG_OP_WRITE));
      chk_flash("reissued_word", 21'h00_3000, 1'b0, 16'habcd);
      apb(1'b1, fmsg_pkg::OFS_STATUS, 32'h0000_000c);
      apb(1'b0, fmsg_pkg::OFS_STATUS, 32'h0000_0000);
      cmp("status_cleared", 32'h0000_0002, rd);
      op(21'h00_0000, 16'h0000, ctrl(1'b1, 1'b0, 1'b0, fmsg_pkg::FMSG_OP_HWRESET));
      cmp("idle_reset_status", 32'h0000_000a, rd);
      chk_flash("read_after_reset", 21'h00_3000, 1'b0, 16'habcd);
      chk_flash("ident_code", 21'h00_0000, 1'b1, 16'h005a);
      chk_flash("sector_verify_set", 21'h00_1002, 1'b1, 16'h0001);
      chk_flash("sector_verify_clear", 21'h00_5002, 1'b1, 16'h0000);
      // address write landing while a read runs is dropped
      apb(1'b1, fmsg_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, fmsg_pkg::FMSG_OP_READ));
      apb(1'b1, fmsg_pkg::OFS_ADDR, 32'h001f_ffff);
      wait_idle(1'b1);
      apb(1'b0, fmsg_pkg::OFS_ADDR, 32'h0000_0000);
      cmp("addr_kept_while_busy", 32'h0000_5002, rd);
      finish_test();
   end

   initial begin
      repeat (40000) @(posedge pclk);
      err_total++;
      $display("BAD watchdog expected done seen timeout");
      finish_test();
   end
endmodule
